// ===== sacl_pkg.sv
// Shared types and constants for the serial converter link.
package sacl_pkg;

  // Result width and the trial code that opens a successive approximation.
  localparam int unsigned RESULT_BITS = 8;
  localparam int unsigned MSB_POS     = RESULT_BITS - 1;
  localparam int unsigned MUX_BITS_MAX = 4;
  localparam logic [7:0]  SAR_START   = 8'h80;
  localparam logic [7:0]  RESULT_RST  = 8'h00;

  // Result FIFO depth.
  localparam int unsigned FIFO_DEPTH = 32;

  // Bench link clock period and its length in system clocks, for reference.
  localparam int unsigned SYS_PERIOD_NS  = 50;
  localparam int unsigned LINK_PERIOD_NS = 400;
  localparam int unsigned LINK_PERIOD_CYC = LINK_PERIOD_NS / SYS_PERIOD_NS;

  // Indices of the synchronised link pins inside one vector.
  localparam int unsigned PIN_CS   = 0;
  localparam int unsigned PIN_CLK  = 1;
  localparam int unsigned PIN_DIN  = 2;
  localparam int unsigned PIN_ORD  = 3;
  localparam int unsigned PIN_CMP  = 4;
  localparam int unsigned PIN_CNT  = 5;
  localparam logic [4:0]  PIN_RST  = 5'h01;

  typedef enum logic [5:0]
  {
    ST_IDLE   = 6'b00_0001,
    ST_ADDR   = 6'b00_0010,
    ST_SETTLE = 6'b00_0100,
    ST_CONV   = 6'b00_1000,
    ST_REV    = 6'b01_0000,
    ST_TAIL   = 6'b10_0000
  } sacl_state_type;

  // Channel assignment as decoded from the multiplexer word.
  typedef struct packed
  {
    logic       single_ended_flag;
    logic       odd_sign;
    logic [1:0] select;
  } sacl_chan_cfg_type;

  // One finished conversion as it enters the result FIFO.
  typedef struct packed
  {
    sacl_chan_cfg_type cfg;
    logic [7:0]        code;
  } sacl_result_type;

endpackage

// ===== sacl_fifo.sv
// Synchronous FIFO that buffers finished conversion results.
`timescale 1ns/10ps
`default_nettype none

module sacl_fifo
#(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
)
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Filling side
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    wr_ptr_d;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW-1:0]    rd_ptr_d;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;
  // The valid output leaves a flip-flop of its own instead of a compare on the count.
  logic             nonempty_q;
  logic             nonempty_d;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign in_ready = (count_q != FULL_CNT);
  assign out_valid = nonempty_q;
  assign out_data = mem_q[rd_ptr_q];

  always_comb
  begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d  = count_q;
    if (push)
    begin
      wr_ptr_d = (wr_ptr_q == LAST_PTR) ? '0 : AW'(wr_ptr_q + 1'b1);
    end
    if (pop)
    begin
      rd_ptr_d = (rd_ptr_q == LAST_PTR) ? '0 : AW'(rd_ptr_q + 1'b1);
    end
    if (push && !pop)
    begin
      count_d = (AW+1)'(count_q + 1'b1);
    end
    else if (pop && !push)
    begin
      count_d = (AW+1)'(count_q - 1'b1);
    end
    nonempty_d = (count_d != '0);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      nonempty_q <= 1'b0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      nonempty_q <= nonempty_d;
    end
  end

  // Storage has no reset; only words below the count are ever read.
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  a_fifo_no_overrun :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (count_q == FULL_CNT) && !pop |=> count_q == FULL_CNT)
    else $error("FIFO count moved past full.");

endmodule

`default_nettype wire

// ===== sacl_link.sv
// Serial link and conversion sequencer of an 8-bit successive-approximation converter.
// Functional notes
// - While addressing, serial input is sampled on each rising link clock edge.
// - Leading zeros are ignored; the first one is the start bit, but ones are refused while the result FIFO is full.
// - Two to four bits after the start bit form the channel assignment.
// - Half a link clock of settling follows the start bit reaching its place.
// - Busy flag rises at settling start; serial input is then ignored.
// - Output leaves high impedance and drives one zero bit for one period.
// - Each comparator decision appears on falling edges, most significant first.
// - Conversion takes eight periods; busy flag drops half a period later.
// - All eight result bits are kept for a reversed send.
// - Without an order pin, the result follows again least significant first.
// - After the reversed stream the output stays low until deselect.
// - With the order pin high the last bit holds; low shifts reversed bits.
// - The single-channel variant sends only the forward stream.
// - Chip select high keeps the sequencer registers but push_data_q cleared; the result FIFO keeps its contents.
// - Input is only looked at while the output is still undriven.
// - Result is an unsigned 8-bit code of 256 values.
// - Word order is single-ended flag, odd or sign bit, then select bits.
// - Positive input below negative input yields an all-zero code.
// - The single-channel variant takes no assignment bits.
`timescale 1ns/10ps
`default_nettype none

module sacl_link
#(
  parameter int unsigned MUX_BITS        = 4,
  parameter bit          HAS_ORDER_PIN   = 1'b0,
  parameter int unsigned FIFO_DEPTH      = sacl_pkg::FIFO_DEPTH
)
(
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  // Serial link pins
  input  wire logic                        chip_select_n,
  input  wire logic                        serial_clock,
  input  wire logic                        serial_in_line,
  input  wire logic                        lsb_first_request_n,
  output var  logic                        serial_out,
  output var  logic                        serial_out_oe_n,
  // Analog front end
  input  wire logic                        comparator_high,
  output var  logic [7:0]                  trial_code,
  output var  sacl_pkg::sacl_chan_cfg_type channel_cfg,
  output var  logic                        conversion_active_flag,
  // Result stream
  output var  logic                        result_valid,
  input  wire logic                        result_ready,
  output var  sacl_pkg::sacl_result_type   result_data
);

  localparam logic [1:0] ADDR_LAST = 2'(MUX_BITS - 1);
  localparam logic [2:0] BIT_MSB   = 3'(sacl_pkg::MSB_POS);

  // Every pin crosses into sys_clk through two flip-flops.
  logic [sacl_pkg::PIN_CNT-1:0] pin_raw;
  logic [sacl_pkg::PIN_CNT-1:0] pin_meta_q;
  logic [sacl_pkg::PIN_CNT-1:0] pin_sync_q;
  logic                         clk_prev_q;
  logic                         cs_s;
  logic                         din_s;
  logic                         ord_n_s;
  logic                         cmp_s;
  logic                         rise;
  logic                         fall;

  assign pin_raw = {comparator_high, lsb_first_request_n, serial_in_line,
                    serial_clock, chip_select_n};

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pin_meta_q <= sacl_pkg::PIN_RST;
      pin_sync_q <= sacl_pkg::PIN_RST;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      clk_prev_q <= pin_sync_q[sacl_pkg::PIN_CLK];
    end
  end

  assign cs_s    = pin_sync_q[sacl_pkg::PIN_CS];
  assign din_s   = pin_sync_q[sacl_pkg::PIN_DIN];
  assign ord_n_s = pin_sync_q[sacl_pkg::PIN_ORD];
  assign cmp_s   = pin_sync_q[sacl_pkg::PIN_CMP];
  assign rise    = pin_sync_q[sacl_pkg::PIN_CLK] && !clk_prev_q;
  assign fall    = !pin_sync_q[sacl_pkg::PIN_CLK] && clk_prev_q;

  // Maps the raw assignment word onto the fields for this channel count.
  function automatic sacl_pkg::sacl_chan_cfg_type decode_cfg(input logic [3:0] w);
    sacl_pkg::sacl_chan_cfg_type c;
    c = '0;
    case (MUX_BITS)
      2:
      begin
        c.single_ended_flag = w[1];
        c.odd_sign          = w[0];
      end
      3:
      begin
        c.single_ended_flag = w[2];
        c.odd_sign          = w[1];
        c.select            = {1'b0, w[0]};
      end
      4:
      begin
        c.single_ended_flag = w[3];
        c.odd_sign          = w[2];
        c.select            = w[1:0];
      end
      default:
      begin
        c = '0;
      end
    endcase
    return c;
  endfunction

  // One approximation step: keep the decision and try the next lower bit.
  function automatic logic [7:0] sar_step(input logic [7:0] t, input logic [2:0] i,
                                          input logic dec);
    logic [7:0] n;
    n    = t;
    n[i] = dec;
    if (i != 3'h0)
    begin
      n[3'(i - 3'h1)] = 1'b1;
    end
    return n;
  endfunction

  sacl_pkg::sacl_state_type    state_q;
  sacl_pkg::sacl_state_type    state_d;
  logic [3:0]                  addr_sr_q;
  logic [3:0]                  addr_sr_d;
  logic [1:0]                  addr_cnt_q;
  logic [1:0]                  addr_cnt_d;
  logic [2:0]                  bit_idx_q;
  logic [2:0]                  bit_idx_d;
  logic [7:0]                  result_q;
  logic [7:0]                  result_d;
  logic [7:0]                  trial_q;
  logic [7:0]                  trial_d;
  sacl_pkg::sacl_chan_cfg_type cfg_q;
  sacl_pkg::sacl_chan_cfg_type cfg_d;
  logic                        flag_q;
  logic                        flag_d;
  logic                        dout_q;
  logic                        dout_d;
  logic                        oe_n_q;
  logic                        oe_n_d;
  logic                        push_q;
  logic                        push_d;
  sacl_pkg::sacl_result_type   push_data_q;
  sacl_pkg::sacl_result_type   push_data_d;
  logic                        fifo_in_ready;

  always_comb
  begin
    state_d     = state_q;
    addr_sr_d   = addr_sr_q;
    addr_cnt_d  = addr_cnt_q;
    bit_idx_d   = bit_idx_q;
    result_d    = result_q;
    trial_d     = trial_q;
    cfg_d       = cfg_q;
    flag_d      = flag_q;
    dout_d      = dout_q;
    oe_n_d      = oe_n_q;
    push_d      = 1'b0;
    push_data_d = push_data_q;
    if (cs_s)
    begin
      // Deselect wipes every sequencer register but push_data_q and floats the output.
      state_d    = sacl_pkg::ST_IDLE;
      addr_sr_d  = '0;
      addr_cnt_d = '0;
      bit_idx_d  = '0;
      result_d   = sacl_pkg::RESULT_RST;
      trial_d    = sacl_pkg::RESULT_RST;
      cfg_d      = '0;
      flag_d     = 1'b0;
      dout_d     = 1'b0;
      oe_n_d     = 1'b1;
    end
    else
    begin
      case (state_q)
        sacl_pkg::ST_IDLE:
        begin
          // Zeros are skipped; a start bit is refused while results cannot be stored.
          if (rise && din_s && fifo_in_ready)
          begin
            if (MUX_BITS == 0)
            begin
              state_d = sacl_pkg::ST_SETTLE;
              flag_d  = 1'b1;
            end
            else
            begin
              state_d    = sacl_pkg::ST_ADDR;
              addr_cnt_d = '0;
            end
          end
        end
        sacl_pkg::ST_ADDR:
        begin
          if (rise)
          begin
            addr_sr_d  = {addr_sr_q[2:0], din_s};
            addr_cnt_d = 2'(addr_cnt_q + 2'h1);
            if (addr_cnt_q == ADDR_LAST)
            begin
              // Word complete: assign the channel and start settling.
              cfg_d   = decode_cfg({addr_sr_q[2:0], din_s});
              state_d = sacl_pkg::ST_SETTLE;
              flag_d  = 1'b1;
            end
          end
        end
        sacl_pkg::ST_SETTLE:
        begin
          // Half a period after the start bit took its place, drive the leading zero.
          if (fall)
          begin
            oe_n_d    = 1'b0;
            dout_d    = 1'b0;
            trial_d   = sacl_pkg::SAR_START;
            bit_idx_d = BIT_MSB;
            state_d   = sacl_pkg::ST_CONV;
          end
        end
        sacl_pkg::ST_CONV:
        begin
          // A low comparator on every trial gives the all-zero code.
          if (fall)
          begin
            dout_d              = cmp_s;
            result_d[bit_idx_q] = cmp_s;
            trial_d             = sar_step(trial_q, bit_idx_q, cmp_s);
            if (bit_idx_q == 3'h0)
            begin
              push_d           = 1'b1;
              push_data_d.cfg  = cfg_q;
              push_data_d.code = {result_q[7:1], cmp_s};
              bit_idx_d        = 3'h1;
              state_d          = (MUX_BITS == 0) ? sacl_pkg::ST_TAIL
                                                 : sacl_pkg::ST_REV;
            end
            else
            begin
              bit_idx_d = 3'(bit_idx_q - 3'h1);
            end
          end
        end
        sacl_pkg::ST_REV:
        begin
          if (rise)
          begin
            flag_d = 1'b0;
          end
          // With an order pin held high the last bit simply stays.
          if (fall && (!HAS_ORDER_PIN || !ord_n_s))
          begin
            dout_d = result_q[bit_idx_q];
            if (bit_idx_q == BIT_MSB)
            begin
              state_d = sacl_pkg::ST_TAIL;
            end
            else
            begin
              bit_idx_d = 3'(bit_idx_q + 3'h1);
            end
          end
        end
        sacl_pkg::ST_TAIL:
        begin
          if (rise)
          begin
            flag_d = 1'b0;
          end
          if (fall)
          begin
            dout_d = 1'b0;
          end
        end
        default:
        begin
          state_d = sacl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q     <= sacl_pkg::ST_IDLE;
      addr_sr_q   <= '0;
      addr_cnt_q  <= '0;
      bit_idx_q   <= '0;
      result_q    <= sacl_pkg::RESULT_RST;
      trial_q     <= sacl_pkg::RESULT_RST;
      cfg_q       <= '0;
      flag_q      <= 1'b0;
      dout_q      <= 1'b0;
      oe_n_q      <= 1'b1;
      push_q      <= 1'b0;
      push_data_q <= '0;
    end
    else
    begin
      state_q     <= state_d;
      addr_sr_q   <= addr_sr_d;
      addr_cnt_q  <= addr_cnt_d;
      bit_idx_q   <= bit_idx_d;
      result_q    <= result_d;
      trial_q     <= trial_d;
      cfg_q       <= cfg_d;
      flag_q      <= flag_d;
      dout_q      <= dout_d;
      oe_n_q      <= oe_n_d;
      push_q      <= push_d;
      push_data_q <= push_data_d;
    end
  end

  assign serial_out             = dout_q;
  assign serial_out_oe_n        = oe_n_q;
  assign trial_code             = trial_q;
  assign channel_cfg            = cfg_q;
  assign conversion_active_flag = flag_q;

  sacl_fifo
  #(
    .WIDTH ($bits(sacl_pkg::sacl_result_type)),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_q),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  a_flag_at_settle :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == sacl_pkg::ST_SETTLE |-> flag_q && oe_n_q)
    else $error("Busy flag low or output driven during settling.");

  a_zero_lead_bit :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == sacl_pkg::ST_SETTLE && fall && !cs_s
      |=> !oe_n_q && !dout_q && trial_q == sacl_pkg::SAR_START)
    else $error("Leading zero bit not driven after settling.");

  a_deselect_clears :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      cs_s |=> state_q == sacl_pkg::ST_IDLE && result_q == '0 && !flag_q)
    else $error("State not cleared while deselected.");

  a_deselect_float :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      cs_s ##1 cs_s |-> oe_n_q)
    else $error("Output driven while deselected.");

  a_input_ignored :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      !cs_s && state_q != sacl_pkg::ST_IDLE && state_q != sacl_pkg::ST_ADDR
      |=> $stable(addr_sr_q))
    else $error("Address register moved after addressing ended.");

  a_decision_out :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == sacl_pkg::ST_CONV && fall && !cs_s
      |=> dout_q == $past(cmp_s) && result_q[$past(bit_idx_q)] == $past(cmp_s))
    else $error("Comparator decision not placed on the output.");

  a_flag_drop :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      (state_q == sacl_pkg::ST_REV || state_q == sacl_pkg::ST_TAIL) && rise
      |=> !flag_q)
    else $error("Busy flag still high after conversion.");

  a_tail_low :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == sacl_pkg::ST_TAIL && fall && !cs_s |=> !dout_q && !oe_n_q)
    else $error("Output not low after the reversed stream.");

  a_order_hold :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      HAS_ORDER_PIN && state_q == sacl_pkg::ST_REV && ord_n_s && !cs_s
      |=> $stable(dout_q))
    else $error("Output moved while the order pin was high.");

  a_start_zeros :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == sacl_pkg::ST_IDLE && rise && !din_s |=> state_q == sacl_pkg::ST_IDLE)
    else $error("A leading zero was taken as a start bit.");

  a_single_forward :
    assert property (@(posedge sys_clk) disable iff (sys_rst)
      MUX_BITS == 0 |-> state_q != sacl_pkg::ST_REV)
    else $error("Single-channel variant entered the reversed stream.");

endmodule

`default_nettype wire

// ===== sacl_host_model.sv
// Host-side model that drives the serial link and records what the converter returns.
`timescale 1ns/10ps
`default_nettype none

module sacl_host_model
(
  // Link pins toward the converter
  output var  logic chip_select_n,
  output var  logic serial_clock,
  output var  logic serial_in_line,
  output var  logic lsb_first_request_n,
  // Pins seen back from the converter
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n,
  input  wire logic conversion_active_flag
);
  logic [23:0] out_seen;
  logic [23:0] oe_seen;
  logic [23:0] flag_seen;

  initial
  begin
    chip_select_n       = 1'b1;
    serial_clock        = 1'b0;
    serial_in_line      = 1'b0;
    lsb_first_request_n = 1'b1;
  end

  // Index j counts link periods from the one whose rising edge carries the start bit.
  // Samples are taken just before each falling edge, when the last output has settled.
  task automatic convert(input int nz, input logic [3:0] word);
    logic [4:0] lead;
    int         j;
    lead = {1'b1, word};
    chip_select_n = 1'b0;
    #400;
    for (int k = 0; k < nz + 24; k++)
    begin
      j = k - nz;
      // Leading zeros, start bit, word MSB first; afterwards the line carries noise.
      if (j < 0)
        serial_in_line = 1'b0;
      else if (j < 5)
        serial_in_line = lead[4 - j];
      else
        serial_in_line = 1'($urandom);
      lsb_first_request_n = 1'($urandom);
      #200 serial_clock = 1'b1;
      #190;
      if (j >= 0)
      begin
        // A floating line shows the inverse of its last value, so an early read cannot pass.
        out_seen[j]  = serial_out_oe_n ? !serial_out : serial_out;
        oe_seen[j]   = serial_out_oe_n;
        flag_seen[j] = conversion_active_flag;
      end
      #10 serial_clock = 1'b0;
    end
    #200 chip_select_n = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// ===== sacl_link_tb.sv
// Self-checking testbench for the serial converter link with its result FIFO.
`timescale 1ns/10ps
`default_nettype none

module sacl_link_tb;
  logic                        sys_clk;
  logic                        sys_rst;
  logic                        chip_select_n;
  logic                        serial_clock;
  logic                        serial_in_line;
  logic                        lsb_first_request_n;
  logic                        serial_out;
  logic                        serial_out_oe_n;
  logic                        comparator_high;
  logic [7:0]                  trial_code;
  sacl_pkg::sacl_chan_cfg_type channel_cfg;
  logic                        conversion_active_flag;
  logic                        result_valid;
  logic                        result_ready;
  sacl_pkg::sacl_result_type   result_data;
  logic [7:0]                  analog_q;
  int                          fail_count;
  int                          total_checks;
  int                          n;
  sacl_pkg::sacl_result_type   exp_q[$];
  sacl_pkg::sacl_result_type   exp_r;
  logic                        serial_out_oe_n_ord;
  logic                        result_valid_ord;
  sacl_pkg::sacl_result_type   result_data_ord;

  sacl_link
  #(
    .MUX_BITS      (4),
    .HAS_ORDER_PIN (1'b0),
    .FIFO_DEPTH    (32)
  )
  u_dut
  (
    .sys_clk                (sys_clk),
    .sys_rst                (sys_rst),
    .chip_select_n          (chip_select_n),
    .serial_clock           (serial_clock),
    .serial_in_line         (serial_in_line),
    .lsb_first_request_n    (lsb_first_request_n),
    .serial_out             (serial_out),
    .serial_out_oe_n        (serial_out_oe_n),
    .comparator_high        (comparator_high),
    .trial_code             (trial_code),
    .channel_cfg            (channel_cfg),
    .conversion_active_flag (conversion_active_flag),
    .result_valid           (result_valid),
    .result_ready           (result_ready),
    .result_data            (result_data)
  );

  // Same converter with the order pin honoured; it shares every input with u_dut.
  sacl_link
  #(
    .MUX_BITS      (4),
    .HAS_ORDER_PIN (1'b1),
    .FIFO_DEPTH    (32)
  )
  u_dut_ord
  (
    .sys_clk                (sys_clk),
    .sys_rst                (sys_rst),
    .chip_select_n          (chip_select_n),
    .serial_clock           (serial_clock),
    .serial_in_line         (serial_in_line),
    .lsb_first_request_n    (lsb_first_request_n),
    .serial_out             (),
    .serial_out_oe_n        (serial_out_oe_n_ord),
    .comparator_high        (comparator_high),
    .trial_code             (),
    .channel_cfg            (),
    .conversion_active_flag (),
    .result_valid           (result_valid_ord),
    .result_ready           (result_ready),
    .result_data            (result_data_ord)
  );

  sacl_host_model u_host
  (
    .chip_select_n          (chip_select_n),
    .serial_clock           (serial_clock),
    .serial_in_line         (serial_in_line),
    .lsb_first_request_n    (lsb_first_request_n),
    .serial_out             (serial_out),
    .serial_out_oe_n        (serial_out_oe_n),
    .conversion_active_flag (conversion_active_flag)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Ideal comparator: the input stands at or above the trial level, so the code equals it.
  always @(negedge sys_clk)
    comparator_high <= (trial_code <= analog_q);

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Forward stream from the period after settling, then the reversed bits, then a low tail.
  function automatic logic [23:0] exp_stream(input logic [7:0] c);
    logic [23:0] s;
    // The line floats during addressing, where the host sees the inverse of a low output.
    s = 24'h00_001F;
    for (int i = 0; i < 8; i++)
      s[6 + i] = c[7 - i];
    for (int i = 1; i < 8; i++)
      s[13 + i] = c[i];
    return s;
  endfunction

  task automatic run_one(input int nz, input logic [3:0] word, input logic [7:0] a,
                         input bit accept);
    analog_q = a;
    @(negedge sys_clk);
    u_host.convert(nz, word);
    if (accept)
    begin
      check("stream", u_host.out_seen, exp_stream(a));
      check("oe_n", u_host.oe_seen, 24'h00_001F);
      check("busy", u_host.flag_seen, 24'h00_1FF0);
      exp_q.push_back({word, a});
    end
    else
    begin
      // A full FIFO leaves the converter idle for the whole transaction.
      check("oe_n idle", u_host.oe_seen, 24'hFF_FFFF);
      check("busy idle", u_host.flag_seen, 24'h00_0000);
    end
    check("oe_n deselected", serial_out_oe_n, 1'b1);
    check("oe_n ordered deselected", serial_out_oe_n_ord, 1'b1);
    check("trial cleared", trial_code, 8'h00);
    check("cfg cleared", channel_cfg, 4'h0);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #1_500_000;
    fail_count++;
    final_report();
  end

  initial
  begin
    sys_rst         = 1'b1;
    result_ready    = 1'b0;
    analog_q        = 8'h00;
    fail_count      = 0;
    total_checks    = 0;
    void'($urandom(32'hfdaa_8dbf));
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("valid after reset", result_valid, 1'b0);
    check("ordered valid after reset", result_valid_ord, 1'b0);
    // Every word once in each polarity half; the consumer stalls until the FIFO is full.
    for (int i = 0; i < 32; i++)
      run_one(i % 3, 4'(i), (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom), 1'b1);
    check("valid when full", result_valid, 1'b1);
    check("ordered valid when full", result_valid_ord, 1'b1);
    run_one(0, 4'h5, 8'h33, 1'b0);
    n = 0;
    while (exp_q.size() > 0 && n < 400)
    begin
      @(negedge sys_clk);
      n++;
      if (result_valid === 1'b1 && ($urandom % 2) == 1)
      begin
        exp_r = exp_q.pop_front();
        check("result", result_data, exp_r);
        check("ordered result", result_data_ord, exp_r);
        result_ready = 1'b1;
      end
      else
        result_ready = 1'b0;
    end
    @(negedge sys_clk);
    result_ready = 1'b0;
    check("drained", exp_q.size(), 0);
    check("valid when empty", result_valid, 1'b0);
    check("ordered valid when empty", result_valid_ord, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
